// >>> hw/bps_pkg.sv
// Constants, register map and state type of the power-mode sequencer
package bps_pkg;
	// Measurement cadence in active mode, and the clock rate
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned MEAS_PERIOD_MS = 1000;
	localparam int unsigned SEC_CYCLES = MEAS_PERIOD_MS * CLK_KHZ;
	localparam int SEC_W = 27;
	// Cadence dividers (in measurement periods) for active, standby and ship modes
	localparam logic [3:0] DIV_ACTIVE = 4'h1;
	localparam logic [3:0] DIV_STANDBY = 4'h4;
	localparam logic [3:0] DIV_SHIP = 4'h8;
	// Register byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SHIP_CMD = 8'h04;
	localparam logic [7:0] REG_UV_TH = 8'h08;
	localparam logic [7:0] REG_RECOV_TH = 8'h0C;
	localparam logic [7:0] REG_IDLE_TIME = 8'h10;
	localparam logic [7:0] REG_STATE = 8'h14;
	localparam logic [7:0] REG_IRQ_STAT = 8'h18;
	localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
	// Control fields: external input polarity (1 = active high), enable
	localparam int CTRL_POL_LSB = 0;
	localparam int CTRL_EXT_EN_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h7;
	// Key that arms ship entry
	localparam logic [31:0] SHIP_KEY = 32'h5A5A0001;
	// Thresholds in millivolts, and idle time in seconds
	localparam logic [15:0] UV_TH_MAX_MV = 16'h0A8B;
	localparam logic [15:0] UV_TH_RST = 16'h09C4;
	localparam logic [15:0] RECOV_TH_RST = 16'h0A8C;
	localparam logic [15:0] IDLE_TIME_RST = 16'h003C;
	// Interrupt status bits
	localparam int IRQ_W = 4;
	localparam int IRQ_STATE = 0;
	localparam int IRQ_TRIP = 1;
	localparam int IRQ_FUSE = 2;
	localparam int IRQ_UV = 3;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_ACTIVE,
		ST_STANDBY,
		ST_SHIP,
		ST_UV
	} bps_state_t;
endpackage

// >>> hw/bps_sync.sv
// Two-flop synchroniser, one stage pair per bit
module bps_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta_r[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta_r[i] <= d[i];
					q[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule // bps_sync

// >>> hw/bps_tick.sv
// Second timer and measurement-cycle divider
module bps_tick
	import bps_pkg::*;
#(
	parameter int unsigned SEC_CYC = SEC_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] div,
	output logic sec_tick,
	output logic meas_tick
);
	logic [SEC_W-1:0] cyc_r;
	logic [3:0] per_r;
	logic sec_end;

	assign sec_end = (cyc_r == SEC_W'(SEC_CYC - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_r <= '0;
			sec_tick <= 1'b0;
		end else begin
			cyc_r <= sec_end ? '0 : cyc_r + 1'b1;
			sec_tick <= sec_end;
		end
	end

	// Slower modes repeat the cycle every div seconds
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_r <= 4'h0;
			meas_tick <= 1'b0;
		end else begin
			meas_tick <= 1'b0;
			if (sec_end) begin
				if (per_r + 4'h1 >= div) begin
					per_r <= 4'h0;
					meas_tick <= 1'b1;
				end else begin
					per_r <= per_r + 4'h1;
				end
			end
		end
	end
endmodule // bps_tick

// >>> hw/bps_seq.sv
// Power-mode and protection-switch sequencer with AXI4-Lite registers
module bps_seq
	import bps_pkg::*;
#(
	parameter int unsigned SEC_CYC = SEC_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bus_clk_line,
	input wire logic bus_data_line,
	input wire logic [1:0] ext_switch_ctrl_in,
	input wire logic charger_present,
	input wire logic load_active,
	input wire logic [15:0] cell_min_mv,
	input wire logic fault_cell_volt,
	input wire logic fault_over_current,
	input wire logic fault_short,
	input wire logic fault_temp,
	input wire logic serious_fault,
	output logic chg_en,
	output logic dsg_en,
	output logic pre_en,
	output logic fuse_drive,
	output logic safety_en,
	output logic ocp_en,
	output logic meas_start,
	output logic flash_log_req,
	output logic [1:0] power_state,
	output logic irq
);
	bps_state_t state_r, state_nxt;
	logic [2:0] ctrl_r;
	logic [15:0] uv_th_r, recov_th_r, idle_time_r, idle_cnt_r;
	logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
	logic ship_armed_r, trip_prev_r, sec_tick, meas_tick, fault_any;
	logic [1:0] line_s, ext_s, ext_act;
	logic [3:0] div, ws_q_r;
	logic aw_got_r, w_got_r, wr_fire, wr_hit;
	logic [ADDR_W-1:0] aw_q_r;
	logic [31:0] w_q_r, rd_mux, wr_old, wr_val;
	bps_sync #(.W(4)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({ext_switch_ctrl_in, bus_data_line, bus_clk_line}),
		.q({ext_s, line_s})
	);
	assign div = (state_r == ST_STANDBY) ? DIV_STANDBY :
		(state_r == ST_SHIP) ? DIV_SHIP : DIV_ACTIVE;
	bps_tick #(.SEC_CYC(SEC_CYC)) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.div(div),
		.sec_tick(sec_tick),
		.meas_tick(meas_tick)
	);
	// Present value of the addressed register, and whether it is writable
	always_comb begin
		wr_hit = 1'b1;
		case (aw_q_r)
			REG_CTRL: wr_old = {29'h0, ctrl_r};
			REG_UV_TH: wr_old = {16'h0, uv_th_r};
			REG_RECOV_TH: wr_old = {16'h0, recov_th_r};
			REG_IDLE_TIME: wr_old = {16'h0, idle_time_r};
			REG_IRQ_MASK: wr_old = {28'h0, irq_mask_r};
			REG_SHIP_CMD, REG_IRQ_STAT: wr_old = 32'h0;
			default: begin
				wr_old = 32'h0;
				wr_hit = 1'b0;
			end
		endcase
	end
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign wr_val[8*b +: 8] = ws_q_r[b] ? w_q_r[8*b +: 8] : wr_old[8*b +: 8];
	end
	// Write channel: address and data taken in either order
	assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_q_r <= '0;
			w_q_r <= '0;
			ws_q_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q_r <= s_axi_awaddr;
				aw_got_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q_r <= s_axi_wdata;
				ws_q_r <= s_axi_wstrb;
				w_got_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// Software-written configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= CTRL_RST;
			uv_th_r <= UV_TH_RST;
			recov_th_r <= RECOV_TH_RST;
			idle_time_r <= IDLE_TIME_RST;
			irq_mask_r <= '0;
		end else if (wr_fire) begin
			case (aw_q_r)
				REG_CTRL: ctrl_r <= wr_val[2:0];
				REG_UV_TH: uv_th_r <= (wr_val[15:0] > UV_TH_MAX_MV) ?
					UV_TH_MAX_MV : wr_val[15:0];
				REG_RECOV_TH: recov_th_r <= wr_val[15:0];
				REG_IDLE_TIME: idle_time_r <= wr_val[15:0];
				REG_IRQ_MASK: irq_mask_r <= wr_val[IRQ_W-1:0];
				default: ;
			endcase
		end
	end
	// Read channel
	always_comb begin
		case (s_axi_araddr)
			REG_CTRL: rd_mux = {29'h0, ctrl_r};
			REG_UV_TH: rd_mux = {16'h0, uv_th_r};
			REG_RECOV_TH: rd_mux = {16'h0, recov_th_r};
			REG_IDLE_TIME: rd_mux = {16'h0, idle_time_r};
			REG_STATE: rd_mux = {28'h0, fuse_drive, ship_armed_r,
				state_r};
			REG_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
			REG_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= (s_axi_araddr == REG_SHIP_CMD ||
				s_axi_araddr > REG_IRQ_MASK ||
				s_axi_araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	// Protected command arms ship entry; any other value disarms
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ship_armed_r <= 1'b0;
		end else if (state_r == ST_SHIP || state_r == ST_UV) begin
			ship_armed_r <= 1'b0;
		end else if (wr_fire && aw_q_r == REG_SHIP_CMD) begin
			ship_armed_r <= (w_q_r == SHIP_KEY) && (ws_q_r == 4'hF);
		end
	end
	// Seconds without load in active mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_cnt_r <= 16'h0;
		end else if (state_r != ST_ACTIVE || load_active) begin
			idle_cnt_r <= 16'h0;
		end else if (sec_tick && idle_cnt_r != 16'hFFFF) begin
			idle_cnt_r <= idle_cnt_r + 16'h1;
		end
	end
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_ACTIVE, ST_STANDBY: begin
				if (cell_min_mv < uv_th_r) begin
					state_nxt = ST_UV;
				end else if (ship_armed_r && !line_s[0] && !line_s[1]) begin
					state_nxt = ST_SHIP;
				end else if (state_r == ST_ACTIVE) begin
					if (!load_active && idle_cnt_r >= idle_time_r) begin
						state_nxt = ST_STANDBY;
					end
				end else if (load_active) begin
					state_nxt = ST_ACTIVE;
				end
			end
			ST_SHIP: begin
				if (line_s[0] || line_s[1]) begin
					state_nxt = ST_ACTIVE;
				end
			end
			ST_UV: begin
				if (cell_min_mv > recov_th_r) begin
					state_nxt = ST_ACTIVE;
				end
			end
			default: state_nxt = ST_ACTIVE;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_ACTIVE;
		end else begin
			state_r <= state_nxt;
		end
	end
	// External inputs, after polarity, force a switch open
	assign ext_act = ctrl_r[CTRL_EXT_EN_BIT] ?
		~(ext_s ^ ctrl_r[CTRL_POL_LSB +: 2]) : 2'b00;
	assign fault_any = fault_cell_volt | fault_over_current |
		fault_short | fault_temp;
	// Switch drive decided from the next state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chg_en <= 1'b0;
			dsg_en <= 1'b0;
			pre_en <= 1'b0;
			safety_en <= 1'b0;
			ocp_en <= 1'b0;
			power_state <= 2'h0;
		end else begin
			power_state <= state_nxt;
			case (state_nxt)
				ST_ACTIVE, ST_STANDBY: begin
					chg_en <= !fault_any && !ext_act[0];
					dsg_en <= !fault_any && !ext_act[1];
					pre_en <= !fault_any && !ext_act[0];
					safety_en <= 1'b1;
					ocp_en <= 1'b1;
				end
				ST_UV: begin
					chg_en <= 1'b0;
					dsg_en <= 1'b0;
					pre_en <= charger_present;
					safety_en <= 1'b0;
					ocp_en <= 1'b0;
				end
				default: begin
					chg_en <= 1'b0;
					dsg_en <= 1'b0;
					pre_en <= 1'b0;
					safety_en <= 1'b0;
					ocp_en <= 1'b0;
				end
			endcase
		end
	end
	// Fuse latches until reset, whatever the switches do
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fuse_drive <= 1'b0;
		end else if (serious_fault) begin
			fuse_drive <= 1'b1;
		end
	end
	// Cycle start pulses and ship-mode log requests
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meas_start <= 1'b0;
			flash_log_req <= 1'b0;
		end else begin
			meas_start <= meas_tick;
			flash_log_req <= meas_tick && state_r == ST_SHIP;
		end
	end
	// Interrupt events; a new event wins over a same-cycle clear
	assign irq_ev[IRQ_STATE] = state_nxt != state_r;
	assign irq_ev[IRQ_TRIP] = fault_any && !trip_prev_r && safety_en;
	assign irq_ev[IRQ_FUSE] = serious_fault && !fuse_drive;
	assign irq_ev[IRQ_UV] = state_nxt == ST_UV && state_r != ST_UV;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= '0;
			trip_prev_r <= 1'b0;
			irq <= 1'b0;
		end else begin
			trip_prev_r <= fault_any;
			if (wr_fire && aw_q_r == REG_IRQ_STAT && ws_q_r[0]) begin
				irq_stat_r <= (irq_stat_r & ~w_q_r[IRQ_W-1:0]) | irq_ev;
			end else begin
				irq_stat_r <= irq_stat_r | irq_ev;
			end
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end
endmodule // bps_seq

// >>> verif/bps_host_model.sv
// Bus host model: two pulled-up lines the host may hold low
module bps_host_model (
	input wire logic aclk,
	input wire logic [1:0] hold_low,
	output logic bus_clk_line,
	output logic bus_data_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released line floats to the pull-up level
	always_ff @(posedge aclk) begin
		bus_clk_line <= !hold_low[0];
		bus_data_line <= !hold_low[1];
	end
endmodule // bps_host_model

// >>> verif/bps_seq_props.sv
// Port checks of the power-mode sequencer
module bps_seq_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bus_clk_line,
	input wire logic bus_data_line,
	input wire logic serious_fault,
	input wire logic charger_present,
	input wire logic chg_en,
	input wire logic dsg_en,
	input wire logic pre_en,
	input wire logic fuse_drive,
	input wire logic safety_en,
	input wire logic ocp_en,
	input wire logic meas_start,
	input wire logic flash_log_req,
	input wire logic [1:0] power_state
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	ship_open_a: assert property (
		power_state == 2'h2 |-> !(chg_en || dsg_en || pre_en))
		else $error("switch closed in ship");
	uv_open_a: assert property (
		power_state == 2'h3 |-> !(chg_en || dsg_en || safety_en))
		else $error("switch closed in shutdown");
	uv_pre_a: assert property (
		power_state == 2'h3 && $past(power_state) == 2'h3
		|-> pre_en == $past(charger_present))
		else $error("pre-charge wrong");
	ocp_mode_a: assert property (
		$past(aresetn) |-> ocp_en == (power_state < 2'h2))
		else $error("ocp enable wrong");
	safety_mode_a: assert property (
		$past(aresetn) |-> safety_en == (power_state < 2'h2))
		else $error("safety enable wrong");
	fuse_set_a: assert property (
		serious_fault |-> ##[1:3] fuse_drive)
		else $error("fuse not driven");
	fuse_hold_a: assert property (
		fuse_drive |=> fuse_drive)
		else $error("fuse dropped");
	flash_ship_a: assert property (
		flash_log_req |-> power_state == 2'h2 || $past(power_state) == 2'h2)
		else $error("log outside ship");
	meas_pulse_a: assert property (
		meas_start |=> !meas_start)
		else $error("long meas pulse");
	ship_exit_a: assert property (
		power_state == 2'h2 && (bus_clk_line || bus_data_line)
		|-> ##[1:6] power_state != 2'h2)
		else $error("ship not left");
	state_exit_a: assert property (
		$changed(power_state) && $past(power_state) >= 2'h2
		|-> power_state == 2'h0)
		else $error("bad exit state");
endmodule // bps_seq_chk

// >>> verif/testbench.sv
// Self-checking bench of the power-mode sequencer
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
	$display("unexpected t=%0t %h %h", $time, a, e); end end
module testbench
	import bps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [1:0] r;
	} bps_row_t;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, power_state, r;
	logic bus_clk_line, bus_data_line;
	logic [1:0] hold_low = 2'h0, ext_switch_ctrl_in = 2'h0;
	logic charger_present = 0, load_active = 1, serious_fault = 0;
	logic fault_cell_volt = 0, fault_over_current = 0;
	logic fault_short = 0, fault_temp = 0;
	logic [15:0] cell_min_mv = 16'h0C80;
	logic chg_en, dsg_en, pre_en, fuse_drive, safety_en, ocp_en;
	logic meas_start, flash_log_req, irq;
	int failures = 0, compares = 0, i, n;
	bps_row_t rows [7] = '{'{REG_CTRL, 32'h7, RESP_OKAY},
		'{REG_UV_TH, {16'h0, UV_TH_RST}, RESP_OKAY},
		'{REG_RECOV_TH, {16'h0, RECOV_TH_RST}, RESP_OKAY},
		'{REG_IDLE_TIME, {16'h0, IDLE_TIME_RST}, RESP_OKAY},
		'{REG_STATE, 32'h0, RESP_OKAY}, '{REG_IRQ_MASK, 32'h0, RESP_OKAY},
		'{REG_SHIP_CMD, 32'h0, RESP_SLVERR}};
	bps_seq #(.SEC_CYC(20)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.bus_clk_line, .bus_data_line, .ext_switch_ctrl_in,
		.charger_present, .load_active, .cell_min_mv, .fault_cell_volt,
		.fault_over_current, .fault_short, .fault_temp, .serious_fault,
		.chg_en, .dsg_en, .pre_en, .fuse_drive, .safety_en, .ocp_en,
		.meas_start, .flash_log_req, .power_state, .irq);
	bps_host_model host_u (.aclk, .hold_low, .bus_clk_line, .bus_data_line);
	always #4 aclk = ~aclk;
	task automatic end_sim();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge aclk);
	endtask
	task automatic wait_ps(input logic [1:0] v);
		int k = 0;
		while (power_state !== v && k < 400) begin
			@(posedge aclk);
			k++;
		end
		`CHK(power_state, v)
		if (k >= 400) end_sim();
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] dt);
		int k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 50);
		r = s_axi_bresp;
		if (k >= 50) failures++;
		if (k >= 50) end_sim();
	endtask
	task automatic axr(input logic [7:0] a);
		int k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (k >= 50) failures++;
		if (k >= 50) end_sim();
	endtask
	task automatic meas(input int c);
		n = 0;
		repeat (c) begin
			@(posedge aclk);
			if (meas_start === 1'b1) n++;
		end
	endtask
	initial begin
		tick(10);
		aresetn <= 1'b1;
		tick(1);
		for (i = 0; i < 7; i++) begin
			axr(rows[i].a);
			`CHK({r, d}, {rows[i].r, rows[i].d})
		end
		axr(8'h21);
		`CHK(r, RESP_SLVERR)
		axw(REG_UV_TH, 32'hFFFF);
		axr(REG_UV_TH);
		`CHK(d, {16'h0, UV_TH_MAX_MV})
		meas(100);
		`CHK(n, 5)
		ext_switch_ctrl_in <= 2'h1;
		tick(5);
		`CHK({chg_en, dsg_en}, 2'h1)
		axw(REG_CTRL, 32'h6);
		tick(3);
		`CHK(chg_en, 1'b1)
		axw(REG_CTRL, 32'h7);
		ext_switch_ctrl_in <= 2'h0;
		for (i = 0; i < 4; i++) begin
			{fault_temp, fault_short, fault_over_current,
				fault_cell_volt} <= 4'h1 << i;
			tick(3);
			`CHK({chg_en, dsg_en}, 2'h0)
			{fault_temp, fault_short, fault_over_current,
				fault_cell_volt} <= 4'h0;
			tick(3);
			`CHK({chg_en, dsg_en}, 2'h3)
		end
		axr(REG_IRQ_STAT);
		`CHK(d[IRQ_TRIP], 1'b1)
		axw(REG_IRQ_STAT, 32'hF);
		axw(REG_IRQ_MASK, 32'h8);
		charger_present <= 1'b1;
		cell_min_mv <= 16'h07D0;
		wait_ps(2'h3);
		tick(2);
		`CHK({chg_en, dsg_en, pre_en, ocp_en, irq}, 5'h5)
		charger_present <= 1'b0;
		tick(2);
		`CHK(pre_en, 1'b0)
		axw(REG_IRQ_MASK, 32'h0);
		tick(2);
		`CHK(irq, 1'b0)
		axw(REG_IRQ_MASK, 32'h8);
		axw(REG_IRQ_STAT, 32'h8);
		tick(2);
		`CHK(irq, 1'b0)
		cell_min_mv <= 16'h0A8D;
		wait_ps(2'h0);
		hold_low <= 2'h3;
		tick(10);
		`CHK(power_state, 2'h0)
		hold_low <= 2'h0;
		tick(5);
		axw(REG_SHIP_CMD, SHIP_KEY);
		hold_low <= 2'h3;
		wait_ps(2'h2);
		tick(1);
		`CHK({chg_en, dsg_en, pre_en, ocp_en}, 4'h0)
		n = 0;
		while (flash_log_req !== 1'b1 && n < 400) begin
			@(posedge aclk);
			n++;
		end
		`CHK(flash_log_req, 1'b1)
		if (n >= 400) end_sim();
		hold_low <= 2'h1;
		wait_ps(2'h0);
		axw(REG_IDLE_TIME, 32'h2);
		load_active <= 1'b0;
		wait_ps(2'h1);
		meas(160);
		`CHK({n[3:0], safety_en}, 5'h5)
		load_active <= 1'b1;
		wait_ps(2'h0);
		serious_fault <= 1'b1;
		tick(3);
		serious_fault <= 1'b0;
		tick(3);
		`CHK(fuse_drive, 1'b1)
		aresetn <= 1'b0;
		tick(3);
		aresetn <= 1'b1;
		tick(2);
		`CHK(fuse_drive, 1'b0)
		end_sim();
	end
endmodule // testbench
bind bps_seq bps_seq_chk chk_u (.aclk, .aresetn, .bus_clk_line,
	.bus_data_line, .serious_fault, .charger_present, .chg_en, .dsg_en,
	.pre_en, .fuse_drive, .safety_en, .ocp_en, .meas_start,
	.flash_log_req, .power_state);
